// ---- logic/hisr_top.sv ----
`timescale 1ns/10ps
module hisr_top (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        HOST_WR,
  input  wire logic [15:0] HOST_WDATA,
  input  wire logic        HOST_RD,
  output logic      [15:0] HOST_RDATA,
  output logic             HOST_IRQ_LINE,
  input  wire logic        LINK_CTRL_EN,
  input  wire logic        RX_CONTINUE_REQ,
  input  wire logic [7:0]  ADP_REQ_CLEAR,
  input  wire logic        ADP_POST,
  input  wire logic [3:0]  ADP_POST_CODE,
  input  wire logic        ADP_DIAG_START,
  input  wire logic        ADP_DIAG_PASS,
  input  wire logic        ADP_INIT_DONE,
  input  wire logic        ADP_FAIL,
  input  wire logic [3:0]  ADP_FAIL_CODE,
  output logic      [15:0] STATUS_WORD
);

  logic [7:0] req_ff;
  logic       irq_ff;
  logic       init_wait_ff;
  logic       diag_run_ff;
  logic       failed_ff;
  logic [3:0] code_ff;
  logic       post_ok;
  logic [15:0] word;

  // Codes that rely on the interface control block exist only with the link-control option.
  function automatic logic link_only_code(input logic [3:0] code);
    return (code == hisr_pkg::CODE_LINK_STATUS) || (code == hisr_pkg::CODE_RX_PENDING);
  endfunction : link_only_code

  // Link-only codes are dropped while the option is off, so they never raise the line.
  assign post_ok = ADP_POST && (LINK_CTRL_EN || !link_only_code(ADP_POST_CODE));

  // Host sets, adapter clears; a set in the same cycle as a clear wins.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      req_ff <= hisr_pkg::REQ_RESET;
    end else begin
      req_ff <= (req_ff & ~ADP_REQ_CLEAR) | (HOST_WR ? HOST_WDATA[7:0] : 8'h00);
    end
  end

  // The adapter side has no clear path here at all.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_ff <= 1'b0;
    end else if (post_ok) begin
      irq_ff <= 1'b1;
    end else if (HOST_WR && !HOST_WDATA[hisr_pkg::BIT_HOST_IRQ]) begin
      irq_ff <= 1'b0;
    end
  end

  // Code loads in the same edge that raises bit 8, so a read never pairs them stale.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      code_ff <= hisr_pkg::CODE_RESET;
    end else if (ADP_FAIL) begin
      code_ff <= ADP_FAIL_CODE;
    end else if (post_ok) begin
      code_ff <= ADP_POST_CODE;
    end
  end

  // Bring-up flags; host writes never reach them.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      diag_run_ff  <= 1'b0;
      init_wait_ff <= 1'b0;
      failed_ff    <= 1'b0;
    end else begin
      if (ADP_DIAG_START) begin
        diag_run_ff  <= 1'b1;
        init_wait_ff <= 1'b0;
        failed_ff    <= 1'b0;
      end else begin
        // A pass in the same cycle as init-done wins, so the set is never lost.
        if (ADP_INIT_DONE) begin
          init_wait_ff <= 1'b0;
        end
        if (ADP_DIAG_PASS) begin
          diag_run_ff  <= 1'b0;
          init_wait_ff <= 1'b1;
        end
        if (ADP_FAIL) begin
          failed_ff <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    word = {code_ff, failed_ff, diag_run_ff, init_wait_ff, irq_ff, req_ff};
    if (!LINK_CTRL_EN) begin
      word[hisr_pkg::BIT_RX_CANCEL] = RX_CONTINUE_REQ;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      HOST_RDATA    <= 16'h0000;
      STATUS_WORD   <= 16'h0000;
      HOST_IRQ_LINE <= 1'b0;
    end else begin
      STATUS_WORD   <= word;
      HOST_IRQ_LINE <= irq_ff;
      if (HOST_RD) begin
        HOST_RDATA <= word;
      end
    end
  end

  a_irq_no_adp_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ($fell(irq_ff) |-> $past(HOST_WR) && !$past(HOST_WDATA[8])))
    else $error("Interrupt flag dropped without a host zero-write.");

  a_irq_set_code: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL |=> irq_ff && code_ff == $past(ADP_POST_CODE)))
    else $error("Interrupt raised with a stale reason code.");

  a_link_codes_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_POST && !LINK_CTRL_EN && ADP_POST_CODE == hisr_pkg::CODE_RX_PENDING && !irq_ff
     && !(HOST_WR && HOST_WDATA[8]) |=> !irq_ff))
    else $error("Link-only code raised the interrupt with the option off.");

  a_req_no_host_clr: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_REQ_CLEAR == 8'h00 |=> (req_ff & $past(req_ff)) == $past(req_ff)))
    else $error("Request bit cleared without adapter clear.");

  a_req_host_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_WR |=> (req_ff & $past(HOST_WDATA[7:0])) == $past(HOST_WDATA[7:0])))
    else $error("Host write failed to set request bits.");

  a_diag_flags: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_DIAG_START |=> diag_run_ff && !init_wait_ff))
    else $error("Diagnostics start did not set test flag.");

  a_init_wait: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_DIAG_PASS && !ADP_DIAG_START |=> init_wait_ff && !diag_run_ff))
    else $error("Diagnostics pass did not raise the init-wait flag.");

  a_fail_code: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_FAIL && !ADP_DIAG_START |=> failed_ff && code_ff == $past(ADP_FAIL_CODE)))
    else $error("Failure flag or code missing.");

  a_read_word: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_RD && !LINK_CTRL_EN |=> HOST_RDATA[5] == $past(RX_CONTINUE_REQ)))
    else $error("Bit 5 does not show receive-continue with option off.");

  // Reusable steps for the multi-cycle checks below.
  sequence s_post_taken;
    post_ok && !ADP_FAIL;
  endsequence : s_post_taken

  sequence s_host_irq_clear;
    HOST_WR && !HOST_WDATA[hisr_pkg::BIT_HOST_IRQ] && !post_ok;
  endsequence : s_host_irq_clear

  sequence s_host_read;
    HOST_RD;
  endsequence : s_host_read

  a_irq_clear_taken: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_host_irq_clear |=> !irq_ff))
    else $error("Host zero-write did not clear the interrupt flag.");

  a_irq_one_ignored: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_WR && HOST_WDATA[hisr_pkg::BIT_HOST_IRQ] && !post_ok && !irq_ff |=> !irq_ff))
    else $error("Host one-write raised the interrupt flag.");

  a_irq_held_high: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (irq_ff && !HOST_WR |=> irq_ff))
    else $error("Interrupt flag dropped with no host write.");

  a_line_follows: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (1'b1 |=> HOST_IRQ_LINE == $past(irq_ff)))
    else $error("Interrupt line does not follow the flag.");

  a_stat_code: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (1'b1 |=> STATUS_WORD[hisr_pkg::CODE_MSB:hisr_pkg::CODE_LSB] == $past(code_ff)))
    else $error("Status word code field is wrong.");

  a_stat_flags: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (1'b1 |=> STATUS_WORD[hisr_pkg::BIT_FAILED:hisr_pkg::BIT_HOST_IRQ] ==
     $past({failed_ff, diag_run_ff, init_wait_ff, irq_ff})))
    else $error("Status word flag bits are wrong.");

  a_stat_req_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (LINK_CTRL_EN |=> STATUS_WORD[hisr_pkg::REQ_MSB:hisr_pkg::REQ_LSB] == $past(req_ff)))
    else $error("Status word request bits are wrong.");

  a_stat_rxc_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!LINK_CTRL_EN |=> STATUS_WORD[hisr_pkg::BIT_RX_CANCEL] == $past(RX_CONTINUE_REQ)))
    else $error("Status word bit 5 does not show receive-continue.");

  a_stat_req_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!LINK_CTRL_EN |=> (STATUS_WORD[7:0] & 8'hdf) == ($past(req_ff) & 8'hdf)))
    else $error("Status word request bits wrong with option off.");

  a_rdata_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!HOST_RD |=> $stable(HOST_RDATA)))
    else $error("Read data changed without a read.");

  a_rdata_code: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_host_read |=> HOST_RDATA[hisr_pkg::CODE_MSB:hisr_pkg::CODE_LSB] == $past(code_ff)))
    else $error("Read code field is wrong.");

  a_rdata_flags: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_RD |=> HOST_RDATA[11:8] == $past({failed_ff, diag_run_ff, init_wait_ff, irq_ff})))
    else $error("Read flag bits are wrong.");

  a_rdata_req_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_RD && LINK_CTRL_EN |=> HOST_RDATA[7:0] == $past(req_ff)))
    else $error("Read request bits are wrong.");

  a_rdata_req_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_RD && !LINK_CTRL_EN |=> (HOST_RDATA[7:0] & 8'hdf) == ($past(req_ff) & 8'hdf)))
    else $error("Read request bits wrong with option off.");

  a_code_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!ADP_FAIL && !post_ok |=> $stable(code_ff)))
    else $error("Reason code changed with no adapter event.");

  a_upper_host_proof: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (HOST_WR && !ADP_FAIL && !post_ok && !ADP_DIAG_START && !ADP_DIAG_PASS && !ADP_INIT_DONE
     |=> $stable({code_ff, failed_ff, diag_run_ff, init_wait_ff})))
    else $error("Host write altered adapter-owned bits.");

  a_link_status_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_POST && !LINK_CTRL_EN && ADP_POST_CODE == hisr_pkg::CODE_LINK_STATUS && !ADP_FAIL
     |=> $stable(code_ff)))
    else $error("Link status code loaded with the option off.");

  a_rx_pending_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_POST && !LINK_CTRL_EN && ADP_POST_CODE == hisr_pkg::CODE_RX_PENDING && !ADP_FAIL
     |=> $stable(code_ff)))
    else $error("Receive pending code loaded with the option off.");

  a_link_codes_open: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_POST && LINK_CTRL_EN && !ADP_FAIL |=> irq_ff && code_ff == $past(ADP_POST_CODE)))
    else $error("Post refused with the option on.");

  a_fail_beats_post: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_FAIL && post_ok |=> irq_ff && code_ff == $past(ADP_FAIL_CODE)))
    else $error("Failure code lost to a same-cycle post.");

  a_fail_no_irq: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_FAIL && !post_ok && !irq_ff |=> !irq_ff))
    else $error("Failure raised the interrupt flag.");

  a_diag_clears: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_DIAG_START |=> !failed_ff && !init_wait_ff))
    else $error("Diagnostics start left error or init-wait set.");

  a_diag_pass_clr: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_DIAG_PASS && !ADP_DIAG_START |=> !diag_run_ff))
    else $error("Diagnostics pass did not clear the test flag.");

  a_diag_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (diag_run_ff && !ADP_DIAG_PASS |=> diag_run_ff))
    else $error("Test flag cleared without a pass.");

  a_init_done_clr: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (ADP_INIT_DONE && !ADP_DIAG_PASS && !ADP_DIAG_START |=> !init_wait_ff))
    else $error("Init done did not clear the init-wait flag.");

  a_init_wait_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (init_wait_ff && !ADP_INIT_DONE && !ADP_DIAG_START |=> init_wait_ff))
    else $error("Init-wait flag cleared too early.");

  a_fail_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (failed_ff && !ADP_DIAG_START |=> failed_ff))
    else $error("Error flag cleared without a new diagnostics run.");

  a_req_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ((ADP_REQ_CLEAR != 8'h00) && !HOST_WR |=> (req_ff & $past(ADP_REQ_CLEAR)) == 8'h00))
    else $error("Adapter clear did not clear request bits.");

  a_req_no_rise: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!HOST_WR |=> (req_ff & ~$past(req_ff)) == 8'h00))
    else $error("Request bit rose without a host write.");

  a_req_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!HOST_WR && ADP_REQ_CLEAR == 8'h00 |=> $stable(req_ff)))
    else $error("Request bits changed with no write or clear.");

  a_irq_no_rise: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!post_ok && !irq_ff |=> !irq_ff))
    else $error("Interrupt flag rose without a post.");

  a_post_then_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_post_taken ##1 s_host_read |=> HOST_RDATA[8] && HOST_RDATA[15:12] == $past(ADP_POST_CODE, 2)))
    else $error("Read after a post shows a stale code.");

  a_clear_then_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_host_irq_clear ##1 HOST_RD |=> !HOST_RDATA[hisr_pkg::BIT_HOST_IRQ]))
    else $error("Read after a host clear still shows bit 8.");

  a_line_after_post: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_post_taken |=> ##1 HOST_IRQ_LINE))
    else $error("Interrupt line did not rise after a post.");

  a_code_adp_check: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (s_post_taken |=> irq_ff && code_ff == $past(ADP_POST_CODE)))
    else $error("Posted reason code not loaded.");

  a_code_ring: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_RING_STATUS |=> code_ff == hisr_pkg::CODE_RING_STATUS))
    else $error("Ring status code not posted.");

  a_code_link: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_LINK_STATUS |=> code_ff == hisr_pkg::CODE_LINK_STATUS))
    else $error("Link status code not posted.");

  a_code_cmd_free: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_CMD_BLK_FREE |=> code_ff == hisr_pkg::CODE_CMD_BLK_FREE))
    else $error("Command block free code not posted.");

  a_code_timer: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_TIMER |=> code_ff == hisr_pkg::CODE_TIMER))
    else $error("Timer code not posted.");

  a_code_cmd_status: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_CMD_STATUS |=> code_ff == hisr_pkg::CODE_CMD_STATUS))
    else $error("Command status code not posted.");

  a_code_rx_status: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_RX_STATUS |=> code_ff == hisr_pkg::CODE_RX_STATUS))
    else $error("Receive status code not posted.");

  a_code_tx_status: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_TX_STATUS |=> code_ff == hisr_pkg::CODE_TX_STATUS))
    else $error("Transmit status code not posted.");

  a_code_rx_pending: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (post_ok && !ADP_FAIL && ADP_POST_CODE == hisr_pkg::CODE_RX_PENDING |=> code_ff == hisr_pkg::CODE_RX_PENDING))
    else $error("Receive pending code not posted.");

endmodule : hisr_top

// ---- shared/hisr_pkg.sv ----
package hisr_pkg;
  localparam int          WORD_W          = 16;
  localparam int          REQ_LSB         = 0;
  localparam int          REQ_MSB         = 7;
  localparam int          BIT_RX_CANCEL   = 5;
  localparam int          BIT_HOST_IRQ    = 8;
  localparam int          BIT_INIT_WAIT   = 9;
  localparam int          BIT_DIAG_RUN    = 10;
  localparam int          BIT_FAILED      = 11;
  localparam int          CODE_LSB        = 12;
  localparam int          CODE_MSB        = 15;
  localparam logic [7:0]  REQ_RESET       = 8'h00;
  localparam logic [3:0]  CODE_RESET      = 4'h0;
  localparam logic [3:0]  CODE_ADAPTER_CHECK = 4'h0;
  localparam logic [3:0]  CODE_RING_STATUS   = 4'h4;
  localparam logic [3:0]  CODE_LINK_STATUS   = 4'h5;
  localparam logic [3:0]  CODE_CMD_BLK_FREE  = 4'h6;
  localparam logic [3:0]  CODE_TIMER         = 4'h7;
  localparam logic [3:0]  CODE_CMD_STATUS    = 4'h8;
  localparam logic [3:0]  CODE_RX_STATUS     = 4'ha;
  localparam logic [3:0]  CODE_TX_STATUS     = 4'hc;
  localparam logic [3:0]  CODE_RX_PENDING    = 4'he;
endpackage : hisr_pkg

// ---- testbench/hisr_host.sv ----
`timescale 1ns/10ps
module hisr_host (
  input  wire logic        CLOCK,
  output logic             HOST_WR,
  output logic [15:0]      HOST_WDATA,
  output logic             HOST_RD
);
  initial begin
    HOST_WR = 1'b0;
    HOST_WDATA = 16'h0000;
    HOST_RD = 1'b0;
  end
  // Released write data shows its inverse, so a stale word can never pass.
  task automatic wr(input logic [15:0] d);
    @(posedge CLOCK);
    HOST_WR <= 1'b1;
    HOST_WDATA <= d;
    @(posedge CLOCK);
    HOST_WR <= 1'b0;
    HOST_WDATA <= ~d;
  endtask : wr
  task automatic rd();
    @(posedge CLOCK);
    HOST_RD <= 1'b1;
    @(posedge CLOCK);
    HOST_RD <= 1'b0;
  endtask : rd
endmodule : hisr_host

// ---- testbench/host_interrupt_status_readback_tb.sv ----
`timescale 1ns/10ps
module host_interrupt_status_readback_tb;
  logic        clock, rstn, wr, rd, irq, lce, rxc, post, dst, dps, idn, fl, e_irq, e_iw, e_dg, e_fl;
  logic [15:0] wd, rdat, sw;
  logic [7:0]  rc, e_req;
  logic [3:0]  pc, fc, e_code;
  logic [3:0]  codes [9] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he};
  int          n_errors, checked, cyc;
  hisr_host u_hisr_host (.CLOCK(clock), .HOST_WR(wr), .HOST_WDATA(wd), .HOST_RD(rd));
  hisr_top u_hisr_top (.CLOCK(clock), .RSTN(rstn), .HOST_WR(wr), .HOST_WDATA(wd), .HOST_RD(rd),
    .HOST_RDATA(rdat), .HOST_IRQ_LINE(irq), .LINK_CTRL_EN(lce), .RX_CONTINUE_REQ(rxc),
    .ADP_REQ_CLEAR(rc), .ADP_POST(post), .ADP_POST_CODE(pc), .ADP_DIAG_START(dst),
    .ADP_DIAG_PASS(dps), .ADP_INIT_DONE(idn), .ADP_FAIL(fl), .ADP_FAIL_CODE(fc), .STATUS_WORD(sw));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [15:0] ew(input logic sub);
    logic [7:0] r;
    r = e_req;
    if (sub && !lce) r[5] = rxc;
    return {e_code, e_fl, e_dg, e_iw, e_irq, r};
  endfunction : ew
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic check();
    u_hisr_host.rd();
    @(negedge clock);
    cmp(rdat, ew(1'b1));
    cmp({15'h0000, irq}, {15'h0000, e_irq});
    cmp(sw & 16'hffdf, ew(1'b0) & 16'hffdf);
  endtask : check
  task automatic hw(input logic [15:0] d);
    u_hisr_host.wr(d);
    e_req |= d[7:0];
    if (!d[8]) e_irq = 1'b0;
  endtask : hw
  // The adapter strobe lasts one cycle; the mirror is updated only after it is taken.
  task automatic act(input int k, input logic [3:0] c, input logic [7:0] m);
    @(posedge clock);
    case (k)
      0: post <= 1'b1;
      1: rc <= m;
      2: dst <= 1'b1;
      3: dps <= 1'b1;
      4: idn <= 1'b1;
      default: fl <= 1'b1;
    endcase
    pc <= c;
    fc <= c;
    @(posedge clock);
    {post, dst, dps, idn, fl} <= 5'h00;
    rc <= 8'h00;
    case (k)
      0: if (lce || (c != hisr_pkg::CODE_LINK_STATUS && c != hisr_pkg::CODE_RX_PENDING)) {e_irq, e_code} = {1'b1, c};
      1: e_req &= ~m;
      2: {e_dg, e_iw, e_fl} = 3'h4;
      3: {e_dg, e_iw} = 2'h1;
      4: e_iw = 1'b0;
      default: {e_fl, e_code} = {1'b1, c};
    endcase
  endtask : act
  task automatic report_and_stop();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {rstn, lce, rxc, post, rc, pc, fc, dst, dps, idn, fl} = '0;
    {e_req, e_irq, e_iw, e_dg, e_fl, e_code} = '0;
    {n_errors, checked, cyc} = '0;
    void'($urandom(4));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    check();
    $display("test reset done");
    for (int i = 0; i < 18; i++) begin
      lce <= (i < 9);
      act(0, codes[i % 9], 8'h00);
      check();
      hw(16'hfe00);
    end
    $display("test codes done");
    for (int i = 0; i < 300; i++) begin
      @(posedge clock);
      lce <= 1'($urandom);
      rxc <= 1'($urandom);
      if (i % 7 == 6) hw(16'($urandom));
      else act($urandom_range(0, 5), codes[$urandom_range(0, 8)], 8'($urandom));
      check();
    end
    $display("test random done");
    report_and_stop();
  end
endmodule : host_interrupt_status_readback_tb
